// ### hw/pwr_seq_pkg.sv
// Constants, types and register map of the power state and safing sequencer.
// Behaviour
// - Early low wake pin returns to sleep.
// - Early-return window lasts 9 ms.
// - Sleep command ignored while wake pin high.
// - Late sleep then off command powers down.
// - Functions other than 33 V select and arm output held off in disabled power states.
// - Charge source only in start-up and run.
// - Safing gate supply blocked before start-up.
// - Passive mode activates crossover and reserve switch.
// - Operating machine starts in Init after reset.
// - First watchdog service moves Init to Diag.
// - Diag takes config; one test at once.
// - Driver switch tests only in Diag.
// - Safing transistor test only in Diag.
// - Diag leaves only on safing/scrap command.
// - Safing left only by machine reset.
// - Scrap command enters Scrap; safing off.
// - Scrap goes only to Arming.
// - Arming asserts output; timeout returns Scrap.
// - Machine reset from POR or watchdog faults.
// - Boost 23 V default; host selects 33 V/off.
// - Boost off on shutdown or battery loss unless hold bit set.
// - Boost undervoltage shown in status.
// - Boost overtemperature latched until flag read.
// - Ground loss stops boost until restored.
// - Passive boost off unless hold bit set.
package pwr_seq_pkg;
    localparam logic [7:0] SYS_CTRL_OFS  = 8'h00;
    localparam logic [7:0] SYSTEM_CONFIG_REG_OFS   = 8'h04;
    localparam logic [7:0] CMD_OFS       = 8'h08;
    localparam logic [7:0] MASK_OFS      = 8'h0c;
    localparam logic [7:0] STATUS_OFS    = 8'h10;
    localparam logic [7:0] FAULT_OFS     = 8'h14;
    localparam int CTRL_BOOST_EN_BIT     = 0;
    localparam int CTRL_BOOST_33V_BIT    = 1;
    localparam int CTRL_CHARGE_BIT       = 2;
    localparam int CTRL_VSF_BIT          = 3;
    localparam int CFG_HOLD_BOOST_BIT    = 0;
    localparam int ST_UV_BIT             = 8;
    localparam int ST_TEST_BIT           = 9;
    localparam int ST_WIN_BIT            = 10;
    localparam int FLT_OT_BIT            = 0;
    localparam logic [3:0] CTRL_RST      = 4'h1;
    localparam logic [3:0] CMD_NONE      = 4'h0;
    localparam logic [3:0] CMD_SLEEP     = 4'h1;
    localparam logic [3:0] CMD_POWEROFF  = 4'h2;
    localparam logic [3:0] CMD_SAFING    = 4'h3;
    localparam logic [3:0] CMD_SCRAP     = 4'h4;
    localparam logic [3:0] CMD_ARM       = 4'h5;
    localparam logic [3:0] CMD_HS_TEST   = 4'h6;
    localparam logic [3:0] CMD_LS_TEST   = 4'h7;
    localparam logic [3:0] CMD_FET_TEST  = 4'h8;
    localparam longint CLK_HZ            = 20000000;
    localparam longint WAKE_HOLD_MS      = 9;
    localparam int WAKE_HOLD_CYC = int'((WAKE_HOLD_MS * CLK_HZ) / 1000);
    localparam int ARM_TIMEOUT_CYC       = 2000;
    typedef enum logic [2:0] {P_OFF, P_MON, P_AWAKE, P_STARTUP, P_RUN, P_SHUT, P_ER} pwr_st_t;
    typedef enum logic [2:0] {O_INIT, O_DIAG, O_SAFING, O_SCRAP, O_ARMING} op_st_t;
    typedef struct packed {
        logic boost_en;
        logic boost_33v;
        logic charge_en;
        logic safing_supply_en;
        logic crossover_drive_out;
        logic er_switch;
        logic drivers_en;
        logic safing_logic_en;
        logic sensor_if_en;
        logic watchdog_en;
        logic arm;
    } func_en_t;
    typedef struct packed {
        logic hs;
        logic ls;
        logic fet;
    } test_t;
endpackage : pwr_seq_pkg

// ### hw/pwr_seq.sv
// Power state gating, operating state machine and reserve boost control with an APB slave.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq #(
    parameter int WAKE_HOLD_CYC   = pwr_seq_pkg::WAKE_HOLD_CYC,
    parameter int ARM_TIMEOUT_CYC = pwr_seq_pkg::ARM_TIMEOUT_CYC
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output var  logic [31:0]           prdata_o,
    output var  logic                  pready_o,
    output var  logic                  pslverr_o,
    input  wire logic                  wake_i,
    input  wire logic                  vbat_ok_i,
    input  wire logic                  supply_ok_i,
    input  wire logic                  vin_low_i,
    input  wire logic                  por_i,
    input  wire logic                  watchdog_machine_reset_i,
    input  wire logic                  wd_fail_i,
    input  wire logic                  wd_service_i,
    input  wire logic                  arming_confirm_line_i,
    input  wire logic                  test_done_i,
    input  wire logic                  boost_uv_i,
    input  wire logic                  boost_ot_i,
    input  wire logic                  gnd_loss_i,
    output var  pwr_seq_pkg::func_en_t func_en_o,
    output var  pwr_seq_pkg::test_t    test_o,
    output var  logic [3:0]            deploy_mask_o,
    output var  logic                  reset_n_o
);
    // Counter widths bound the parameters that the logic can serve.
    if (WAKE_HOLD_CYC < 2 || WAKE_HOLD_CYC >= (1 << 18)) begin : g_bad_hold
        $error("WAKE_HOLD_CYC out of range");
    end
    if (ARM_TIMEOUT_CYC < 2 || ARM_TIMEOUT_CYC >= (1 << 16)) begin : g_bad_arm
        $error("ARM_TIMEOUT_CYC out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    pwr_seq_pkg::pwr_st_t  pwr_ff;
    pwr_seq_pkg::pwr_st_t  nxt_pwr;
    pwr_seq_pkg::op_st_t   op_ff;
    pwr_seq_pkg::op_st_t   nxt_op;
    pwr_seq_pkg::func_en_t en_ff;
    pwr_seq_pkg::func_en_t nxt_en;
    pwr_seq_pkg::test_t    test_ff;
    logic [3:0]            ctrl_ff;
    logic                  hold_boost_ff;
    logic [3:0]            cmd_ff;
    logic [3:0]            mask_ff;
    logic                  ot_ff;
    logic                  uv_ff;
    logic [17:0]           hold_cnt_ff;
    logic [15:0]           arm_cnt_ff;
    logic                  rst_n_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic                  ssm_rst;
    logic                  active;
    logic                  passive;
    logic                  window;
    logic                  wr_done;
    logic                  rd_done;
    logic                  test_req;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == pwr_seq_pkg::SYS_CTRL_OFS) || (a == pwr_seq_pkg::SYSTEM_CONFIG_REG_OFS) ||
                 (a == pwr_seq_pkg::CMD_OFS) || (a == pwr_seq_pkg::MASK_OFS) ||
                 (a == pwr_seq_pkg::STATUS_OFS) || (a == pwr_seq_pkg::FAULT_OFS);
    endfunction : mapped

    assign ssm_rst = por_i || watchdog_machine_reset_i || wd_fail_i;
    assign active  = (pwr_ff == pwr_seq_pkg::P_STARTUP) || (pwr_ff == pwr_seq_pkg::P_RUN);
    assign passive = (pwr_ff == pwr_seq_pkg::P_SHUT) || (pwr_ff == pwr_seq_pkg::P_ER);
    assign window  = active && (hold_cnt_ff != 18'h00000);
    assign wr_done = psel_i && penable_i && pready_ff && pwrite_i;
    assign rd_done = psel_i && penable_i && pready_ff && !pwrite_i;
    assign test_req = (cmd_ff == pwr_seq_pkg::CMD_HS_TEST) ||
                      (cmd_ff == pwr_seq_pkg::CMD_LS_TEST) ||
                      (cmd_ff == pwr_seq_pkg::CMD_FET_TEST);

    ////////////////////////////////////////////////////////////////////////////////
    // The slave answers in the first access cycle; read data is captured at setup.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= psel_i && !penable_i;
            pslverr_ff <= psel_i && !penable_i && !mapped(paddr_i);
            prdata_ff  <= 32'h00000000;
            if (psel_i && !penable_i && !pwrite_i) begin
                case (paddr_i)
                    pwr_seq_pkg::SYS_CTRL_OFS: prdata_ff[3:0] <= ctrl_ff;
                    pwr_seq_pkg::SYSTEM_CONFIG_REG_OFS:  prdata_ff[0] <= hold_boost_ff;
                    pwr_seq_pkg::MASK_OFS:     prdata_ff[3:0] <= mask_ff;
                    pwr_seq_pkg::STATUS_OFS: begin
                        prdata_ff[2:0] <= pwr_ff;
                        prdata_ff[6:4] <= op_ff;
                        prdata_ff[pwr_seq_pkg::ST_UV_BIT] <= uv_ff;
                        prdata_ff[pwr_seq_pkg::ST_TEST_BIT] <= |test_ff;
                        prdata_ff[pwr_seq_pkg::ST_WIN_BIT] <= window;
                    end
                    pwr_seq_pkg::FAULT_OFS: prdata_ff[pwr_seq_pkg::FLT_OT_BIT] <= ot_ff;
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff       <= pwr_seq_pkg::CTRL_RST;
            hold_boost_ff <= 1'b0;
            mask_ff       <= 4'h0;
        end else if (wr_done) begin
            if (paddr_i == pwr_seq_pkg::SYS_CTRL_OFS) begin
                ctrl_ff <= pwdata_i[3:0];
            end
            if (paddr_i == pwr_seq_pkg::SYSTEM_CONFIG_REG_OFS) begin
                hold_boost_ff <= pwdata_i[pwr_seq_pkg::CFG_HOLD_BOOST_BIT];
            end
            if (paddr_i == pwr_seq_pkg::MASK_OFS && op_ff == pwr_seq_pkg::O_DIAG) begin
                mask_ff <= pwdata_i[3:0];
            end
        end
    end

    // A command is decoded into a one-cycle pulse; the machines act on the next edge.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_ff <= pwr_seq_pkg::CMD_NONE;
        end else if (wr_done && paddr_i == pwr_seq_pkg::CMD_OFS) begin
            cmd_ff <= pwdata_i[3:0];
        end else begin
            cmd_ff <= pwr_seq_pkg::CMD_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A new thermal event wins over the read that clears the flag.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ot_ff <= 1'b0;
            uv_ff <= 1'b0;
        end else begin
            uv_ff <= boost_uv_i;
            ot_ff <= boost_ot_i || (ot_ff && !(rd_done && paddr_i == pwr_seq_pkg::FAULT_OFS
                     && prdata_ff[pwr_seq_pkg::FLT_OT_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state machine; in start-up and run a low input voltage wins over every other cause.
    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            pwr_seq_pkg::P_OFF: begin
                if (wake_i) begin
                    nxt_pwr = pwr_seq_pkg::P_MON;
                end
            end
            pwr_seq_pkg::P_MON: begin
                nxt_pwr = wake_i ? pwr_seq_pkg::P_AWAKE : pwr_seq_pkg::P_OFF;
            end
            pwr_seq_pkg::P_AWAKE: begin
                if (!wake_i) begin
                    nxt_pwr = pwr_seq_pkg::P_MON;
                end else if (vbat_ok_i) begin
                    nxt_pwr = pwr_seq_pkg::P_STARTUP;
                end
            end
            pwr_seq_pkg::P_STARTUP, pwr_seq_pkg::P_RUN: begin
                if (vin_low_i) begin
                    nxt_pwr = pwr_seq_pkg::P_ER;
                end else if (!wake_i && window) begin
                    nxt_pwr = pwr_seq_pkg::P_AWAKE;
                end else if (!wake_i && cmd_ff == pwr_seq_pkg::CMD_SLEEP) begin
                    nxt_pwr = pwr_seq_pkg::P_SHUT;
                end else if (pwr_ff == pwr_seq_pkg::P_STARTUP && supply_ok_i) begin
                    nxt_pwr = pwr_seq_pkg::P_RUN;
                end
            end
            pwr_seq_pkg::P_SHUT: begin
                if (cmd_ff == pwr_seq_pkg::CMD_POWEROFF) begin
                    nxt_pwr = pwr_seq_pkg::P_OFF;
                end
            end
            pwr_seq_pkg::P_ER: nxt_pwr = pwr_seq_pkg::P_ER;
            default: nxt_pwr = pwr_seq_pkg::P_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_ff <= pwr_seq_pkg::P_OFF;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // The early-return window is armed on every entry into start-up.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt_ff <= 18'h00000;
        end else if (pwr_ff == pwr_seq_pkg::P_AWAKE && nxt_pwr == pwr_seq_pkg::P_STARTUP) begin
            hold_cnt_ff <= 18'(WAKE_HOLD_CYC);
        end else if (hold_cnt_ff != 18'h00000) begin
            hold_cnt_ff <= hold_cnt_ff - 18'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operating state machine; a machine reset overrides every transition.
    always_comb begin
        nxt_op = op_ff;
        case (op_ff)
            pwr_seq_pkg::O_INIT: begin
                if (wd_service_i) begin
                    nxt_op = pwr_seq_pkg::O_DIAG;
                end
            end
            pwr_seq_pkg::O_DIAG: begin
                if (cmd_ff == pwr_seq_pkg::CMD_SAFING) begin
                    nxt_op = pwr_seq_pkg::O_SAFING;
                end else if (cmd_ff == pwr_seq_pkg::CMD_SCRAP) begin
                    nxt_op = pwr_seq_pkg::O_SCRAP;
                end
            end
            pwr_seq_pkg::O_SAFING: nxt_op = pwr_seq_pkg::O_SAFING;
            pwr_seq_pkg::O_SCRAP: begin
                if (cmd_ff == pwr_seq_pkg::CMD_ARM) begin
                    nxt_op = pwr_seq_pkg::O_ARMING;
                end
            end
            pwr_seq_pkg::O_ARMING: begin
                if (arm_cnt_ff == 16'h0001 && !arming_confirm_line_i) begin
                    nxt_op = pwr_seq_pkg::O_SCRAP;
                end
            end
            default: nxt_op = pwr_seq_pkg::O_INIT;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_ff <= pwr_seq_pkg::O_INIT;
        end else if (ssm_rst) begin
            op_ff <= pwr_seq_pkg::O_INIT;
        end else begin
            op_ff <= nxt_op;
        end
    end

    // A correct confirmation restarts the arming time-out.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_cnt_ff <= 16'h0000;
        end else if (op_ff != pwr_seq_pkg::O_ARMING || arming_confirm_line_i) begin
            arm_cnt_ff <= 16'(ARM_TIMEOUT_CYC);
        end else if (arm_cnt_ff != 16'h0000) begin
            arm_cnt_ff <= arm_cnt_ff - 16'h0001;
        end
    end

    // Only one test runs; a request while busy or outside Diag is dropped.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            test_ff <= '0;
        end else if (op_ff != pwr_seq_pkg::O_DIAG || ssm_rst || test_done_i) begin
            test_ff <= '0;
        end else if (test_ff == '0 && test_req) begin
            test_ff.hs  <= cmd_ff == pwr_seq_pkg::CMD_HS_TEST;
            test_ff.ls  <= cmd_ff == pwr_seq_pkg::CMD_LS_TEST;
            test_ff.fet <= cmd_ff == pwr_seq_pkg::CMD_FET_TEST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enables are decoded here and registered so each output leaves a flip-flop.
    always_comb begin
        nxt_en = '0;
        nxt_en.boost_en = (active || (passive && hold_boost_ff))
                          && ctrl_ff[pwr_seq_pkg::CTRL_BOOST_EN_BIT]
                          && !ot_ff && !boost_ot_i
                          && !gnd_loss_i;
        nxt_en.boost_33v = ctrl_ff[pwr_seq_pkg::CTRL_BOOST_33V_BIT];
        nxt_en.charge_en = active && ctrl_ff[pwr_seq_pkg::CTRL_CHARGE_BIT];
        nxt_en.safing_supply_en = (active || passive) && ctrl_ff[pwr_seq_pkg::CTRL_VSF_BIT];
        nxt_en.crossover_drive_out = passive;
        nxt_en.er_switch = passive;
        nxt_en.drivers_en = active || passive;
        nxt_en.safing_logic_en = (active || passive) && op_ff == pwr_seq_pkg::O_SAFING;
        nxt_en.sensor_if_en = (active || passive) && op_ff != pwr_seq_pkg::O_SCRAP
                              && op_ff != pwr_seq_pkg::O_ARMING;
        nxt_en.watchdog_en = active || pwr_ff == pwr_seq_pkg::P_SHUT;
        nxt_en.arm = op_ff == pwr_seq_pkg::O_ARMING;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_ff    <= '0;
            rst_n_ff <= 1'b0;
        end else begin
            en_ff    <= nxt_en;
            rst_n_ff <= !ssm_rst;
        end
    end

    // Output ports are plain copies of registers.
    assign prdata_o      = prdata_ff;
    assign pready_o      = pready_ff;
    assign pslverr_o     = pslverr_ff;
    assign func_en_o     = en_ff;
    assign test_o        = test_ff;
    assign deploy_mask_o = mask_ff;
    assign reset_n_o     = rst_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_charge_gate: assert property (en_ff.charge_en |-> $past(active))
        else $error("charge source on outside start-up or run");
    a_vsf_gate: assert property (en_ff.safing_supply_en |-> $past(active || passive))
        else $error("safing gate supply on before start-up");
    a_passive_switch: assert property ($past(passive)
        |-> en_ff.er_switch && en_ff.crossover_drive_out)
        else $error("passive mode without crossover and reserve switch");
    a_passive_boost: assert property ($past(passive && !hold_boost_ff)
        |-> !en_ff.boost_en)
        else $error("boost left on in passive mode without hold bit");
    a_early_sleep: assert property (window && !wake_i && !vin_low_i
        |=> pwr_ff == pwr_seq_pkg::P_AWAKE)
        else $error("low wake pin in window did not return to sleep");
    a_sleep_ignored: assert property (pwr_ff == pwr_seq_pkg::P_RUN && wake_i && !vin_low_i
        |=> pwr_ff == pwr_seq_pkg::P_RUN)
        else $error("run left while wake pin high");
    a_init_diag: assert property (op_ff == pwr_seq_pkg::O_INIT && wd_service_i && !ssm_rst
        |=> op_ff == pwr_seq_pkg::O_DIAG)
        else $error("first watchdog service did not reach Diag");
    a_safing_stays: assert property (op_ff == pwr_seq_pkg::O_SAFING && !ssm_rst
        |=> op_ff == pwr_seq_pkg::O_SAFING)
        else $error("Safing left without machine reset");
    a_scrap_exit: assert property (op_ff == pwr_seq_pkg::O_SCRAP && !ssm_rst
        |=> op_ff inside {pwr_seq_pkg::O_SCRAP, pwr_seq_pkg::O_ARMING})
        else $error("Scrap left to a state other than Arming");
    a_arm_output: assert property (op_ff == pwr_seq_pkg::O_ARMING |=> en_ff.arm)
        else $error("arming output missing in Arming");
    a_cmd_delay: assert property (wr_done && paddr_i == pwr_seq_pkg::CMD_OFS
        && pwdata_i[3:0] == pwr_seq_pkg::CMD_SCRAP && op_ff == pwr_seq_pkg::O_DIAG && !ssm_rst
        |=> op_ff == pwr_seq_pkg::O_DIAG
        ##1 op_ff == pwr_seq_pkg::O_SCRAP || $past(ssm_rst))
        else $error("scrap command timing wrong");
    a_ot_blocks: assert property (ot_ff |=> !en_ff.boost_en)
        else $error("boost on while overtemperature latched");
    a_test_single: assert property ($onehot0(test_ff))
        else $error("more than one test active");
    a_test_diag: assert property ($rose(|test_ff) |-> $past(op_ff) == pwr_seq_pkg::O_DIAG)
        else $error("test started outside Diag");
    a_reset_pin: assert property (ssm_rst |=> !reset_n_o)
        else $error("reset pin not asserted on machine reset");

    c_safing: cover property (op_ff == pwr_seq_pkg::O_DIAG ##1 op_ff == pwr_seq_pkg::O_SAFING);
    c_arm_back: cover property (op_ff == pwr_seq_pkg::O_ARMING ##1 op_ff == pwr_seq_pkg::O_SCRAP);
    c_shutdown: cover property (pwr_ff == pwr_seq_pkg::P_SHUT ##1 pwr_ff == pwr_seq_pkg::P_OFF);
    c_hs_test: cover property ($rose(test_ff.hs));
    c_er_entry: cover property (pwr_ff == pwr_seq_pkg::P_RUN ##1 pwr_ff == pwr_seq_pkg::P_ER);
endmodule : pwr_seq
`default_nettype wire

// ### testbench/host_model.sv
// Host model: an APB master that issues register accesses and commands.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output var  logic        psel_o,
    output var  logic        penable_o,
    output var  logic        pwrite_o,
    output var  logic [7:0]  paddr_o,
    output var  logic [31:0] pwdata_o,
    output var  logic        hang_o
);
    initial begin
        {psel_o, penable_o, pwrite_o, hang_o} = 4'h0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // Released address and data lines show the inverse of their last value.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_o <= 1'h1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'h1 && n < 16);
        hang_o <= (pready_i !== 1'h1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'h0;
        penable_o <= 1'h0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ### testbench/pwr_seq_tb.sv
// Self-checking bench for the power state and safing sequencer.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_tb;
    logic                  clk, rst, psel, pen, pwr, rdy, err, hang, rstn;
    logic                  wake, vbat, sup, por, wds, tdone, uv, ot, gnd, arming_confirm_line, vlow, wdf;
    logic [7:0]            addr;
    logic [31:0]           wdat, rdat;
    logic [3:0]            dmask;
    pwr_seq_pkg::func_en_t fe;
    pwr_seq_pkg::test_t    tst;
    int                    n_mismatch = 0;
    int                    total_checks = 0;

    host_model h (.clk_i(clk), .pready_i(rdy), .pslverr_i(err), .prdata_i(rdat),
        .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wdat),
        .hang_o(hang));
    pwr_seq #(.WAKE_HOLD_CYC(20), .ARM_TIMEOUT_CYC(8)) DUT (.core_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat),
        .prdata_o(rdat), .pready_o(rdy), .pslverr_o(err), .wake_i(wake), .vbat_ok_i(vbat),
        .supply_ok_i(sup), .vin_low_i(vlow), .por_i(por), .watchdog_machine_reset_i(1'h0),
        .wd_fail_i(wdf), .wd_service_i(wds), .arming_confirm_line_i(arming_confirm_line),
        .test_done_i(tdone), .boost_uv_i(uv), .boost_ot_i(ot), .gnd_loss_i(gnd),
        .func_en_o(fe), .test_o(tst), .deploy_mask_o(dmask), .reset_n_o(rstn));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input logic ee);
        logic [31:0] q;
        logic        x;
        h.xfer(1'h0, a, 32'h0, q, x);
        chk("prdata", e, q & m);
        chk("pslverr", {31'h0, ee}, {31'h0, x});
    endtask : rdc
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        x;
        h.xfer(1'h1, a, d, q, x);
        tick(3);
    endtask : wrr
    task automatic cmd(input logic [3:0] c);
        wrr(pwr_seq_pkg::CMD_OFS, {28'h0, c});
    endtask : cmd
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rdc(pwr_seq_pkg::STATUS_OFS, m, e, 1'h0);
    endtask : st
    task automatic fchk(input logic [31:0] m, input logic [31:0] e);
        chk("func_en", e, {21'h0, fe} & m);
    endtask : fchk

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge hang) begin
        n_mismatch++;
        conclude();
    end
    initial begin
        rst = 1'h1;
        {wake, vbat, sup, por, wds, tdone, uv, ot, gnd, arming_confirm_line, vlow, wdf} = 12'h0;
        tick(5);
        rst <= 1'h0;
        tick(2);
        fchk(32'h7ff, 32'h0);
        st(32'h77, 32'h0);
        rdc(pwr_seq_pkg::SYS_CTRL_OFS, 32'hf, 32'h1, 1'h0);
        {wake, vbat, sup} <= 3'h7;
        tick(40);
        st(32'h7, 32'h4);
        fchk(32'h7e0, 32'h400);
        wrr(pwr_seq_pkg::SYS_CTRL_OFS, 32'hf);
        fchk(32'h7e0, 32'h780);
        cmd(pwr_seq_pkg::CMD_SLEEP);
        st(32'h7, 32'h4);
        wds <= 1'h1;
        tick(1);
        wds <= 1'h0;
        tick(2);
        st(32'h70, 32'h10);
        cmd(pwr_seq_pkg::CMD_ARM);
        st(32'h70, 32'h10);
        cmd(pwr_seq_pkg::CMD_HS_TEST);
        cmd(pwr_seq_pkg::CMD_LS_TEST);
        chk("test", 32'h4, {29'h0, tst});
        tdone <= 1'h1;
        tick(1);
        tdone <= 1'h0;
        tick(3);
        cmd(pwr_seq_pkg::CMD_FET_TEST);
        chk("test", 32'h1, {29'h0, tst});
        cmd(pwr_seq_pkg::CMD_SCRAP);
        st(32'h70, 32'h30);
        fchk(32'hc, 32'h0);
        cmd(pwr_seq_pkg::CMD_HS_TEST);
        chk("test", 32'h0, {29'h0, tst});
        cmd(pwr_seq_pkg::CMD_SAFING);
        st(32'h70, 32'h30);
        cmd(pwr_seq_pkg::CMD_ARM);
        arming_confirm_line <= 1'h1;
        tick(15);
        arming_confirm_line <= 1'h0;
        fchk(32'h1, 32'h1);
        tick(15);
        st(32'h70, 32'h30);
        fchk(32'h1, 32'h0);
        ot <= 1'h1;
        tick(3);
        ot <= 1'h0;
        tick(3);
        fchk(32'h400, 32'h0);
        rdc(pwr_seq_pkg::FAULT_OFS, 32'h1, 32'h1, 1'h0);
        tick(3);
        fchk(32'h400, 32'h400);
        gnd <= 1'h1;
        tick(3);
        fchk(32'h400, 32'h0);
        gnd <= 1'h0;
        tick(3);
        fchk(32'h400, 32'h400);
        uv <= 1'h1;
        tick(3);
        st(32'h100, 32'h100);
        uv <= 1'h0;
        rdc(8'h20, 32'hffffffff, 32'h0, 1'h1);
        por <= 1'h1;
        tick(3);
        chk("reset_n", 32'h0, {31'h0, rstn});
        por <= 1'h0;
        tick(3);
        chk("reset_n", 32'h1, {31'h0, rstn});
        st(32'h70, 32'h0);
        wds <= 1'h1;
        tick(1);
        wds <= 1'h0;
        wrr(pwr_seq_pkg::MASK_OFS, 32'ha);
        chk("mask", 32'ha, {28'h0, dmask});
        cmd(pwr_seq_pkg::CMD_SAFING);
        st(32'h70, 32'h20);
        fchk(32'hc, 32'hc);
        cmd(pwr_seq_pkg::CMD_SCRAP);
        wrr(pwr_seq_pkg::MASK_OFS, 32'h5);
        chk("mask", 32'ha, {28'h0, dmask});
        st(32'h70, 32'h20);
        wdf <= 1'h1;
        tick(1);
        wdf <= 1'h0;
        tick(2);
        st(32'h70, 32'h0);
        wake <= 1'h0;
        tick(5);
        st(32'h7, 32'h4);
        cmd(pwr_seq_pkg::CMD_SLEEP);
        st(32'h7, 32'h5);
        fchk(32'h560, 32'h60);
        wrr(pwr_seq_pkg::SYSTEM_CONFIG_REG_OFS, 32'h1);
        fchk(32'h400, 32'h400);
        cmd(pwr_seq_pkg::CMD_POWEROFF);
        st(32'h7, 32'h0);
        wake <= 1'h1;
        tick(6);
        wake <= 1'h0;
        tick(8);
        st(32'h7, 32'h0);
        wake <= 1'h1;
        tick(6);
        wrr(pwr_seq_pkg::SYSTEM_CONFIG_REG_OFS, 32'h0);
        vlow <= 1'h1;
        tick(3);
        st(32'h7, 32'h6);
        fchk(32'h560, 32'h60);
        rst <= 1'h1;
        {wake, vlow} <= 2'h0;
        tick(2);
        rst <= 1'h0;
        tick(2);
        fchk(32'h7ff, 32'h0);
        st(32'h77, 32'h0);
        conclude();
    end
endmodule : pwr_seq_tb
`default_nettype wire
